// ==== hdl/serial_pkg.sv ====
// Shared types and constants for the synchronous serial port.
// Assumes a single 200 MHz system clock and an AHB-Lite register bus.
package serial_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register indices; the byte address of each register is four times its index.
  localparam logic [29:0] DATA_IDX = 30'h00fffe60;
  localparam logic [29:0] CTRL_IDX = 30'h00fffe62;
  localparam logic [29:0] STAT_IDX = 30'h00fffe64;

  // Status register field positions.
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_FULL_BIT = 1;
  localparam int STAT_OVR_BIT = 2;

  // Word widths in bits and shift-clock toggles per word.
  localparam logic [5:0] BITS_NARROW = 6'h08;
  localparam logic [5:0] BITS_WIDE = 6'h10;
  localparam logic [5:0] TOGGLES_NARROW = 6'h10;
  localparam logic [5:0] TOGGLES_WIDE = 6'h20;

  // AHB transfer type: bit 1 set marks NONSEQ or SEQ.
  localparam int HTRANS_ACTIVE_BIT = 1;

  // System clock.
  localparam int SYS_CLK_MHZ = 200;

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [6:0] clock_divider;
    logic clock_idle_level;
    logic clock_edge_alternate;
    logic transfer_done_irq_en;
    logic read_full_irq_en;
    logic overrun_irq_en;
    logic echo_back_enable;
    logic word_width_select;
    logic master_select;
    logic port_enable;
  } ctrl_t;

  localparam ctrl_t CTRL_RESET = 16'h0000;

  typedef enum logic [1:0] {
    SEL_NONE = 2'b00,
    SEL_DATA = 2'b01,
    SEL_CTRL = 2'b10,
    SEL_STAT = 2'b11
  } reg_sel_t;

  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hready;
  } ahb_req_t;

  typedef struct packed {
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
  } ahb_rsp_t;

  typedef struct packed {
    ctrl_t ctrl;
    logic [15:0] shifter;
    logic [15:0] read_buf;
    logic busy;
    logic full;
    logic receive_overrun;
    logic pending;
    logic valid;
    logic running;
    logic sclk;
    logic out_bit;
    logic [5:0] cnt;
    logic [31:0] hrdata;
    reg_sel_t wr_sel;
  } port_st_t;

  localparam port_st_t PORT_RESET = '0;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } sync_st_t;

  localparam sync_st_t SYNC_RESET = 3'h0;

  typedef struct packed {
    logic [6:0] cnt;
  } div_st_t;

  localparam div_st_t DIV_RESET = 7'h00;

endpackage

// ==== hdl/sig_sync.sv ====
// Two-flop synchroniser with edge detection on the synchronised level.
// Assumes the input is asynchronous to ref_clk and slower than half its rate.
`timescale 1ns/1ps
module sig_sync (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Raw input
  input wire logic d_in,
  // Synchronised level and edges
  output logic level,
  output logic rise,
  output logic fall
);
  import serial_pkg::*;

  sync_st_t st_ff;
  sync_st_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.s1 = d_in;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_ff <= SYNC_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // The first stage feeds only the second; edges are taken after it.
  assign level = st_ff.s2;
  assign rise = st_ff.s2 & ~st_ff.s3;
  assign fall = ~st_ff.s2 & st_ff.s3;
endmodule // sig_sync

// ==== hdl/shift_clk_div.sv ====
// Shift-clock divider: a one-cycle tick every (div + 1) system clocks while run.
// Assumes div is held stable while run is high.
`timescale 1ns/1ps
module shift_clk_div (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Control
  input wire logic run,
  input wire logic [6:0] div,
  // Half-period tick
  output logic tick
);
  import serial_pkg::*;

  div_st_t st_ff;
  div_st_t nxt_st;

  assign tick = run && (st_ff.cnt == div);

  always_comb begin
    nxt_st = st_ff;
    if (!run || tick) begin
      nxt_st.cnt = 7'h00;
    end else begin
      nxt_st.cnt = st_ff.cnt + 7'h01;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_ff <= DIV_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end
endmodule // shift_clk_div

// ==== hdl/serial_port.sv ====
// Synchronous serial port, master or slave, 8- or 16-bit words, AHB-Lite registers.
// Assumes one 200 MHz clock, single-word AHB transfers, and pins resolved outside.
//
// The AHB-Lite slave port was left to the implementer.
`timescale 1ns/1ps
module serial_port (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Register bus
  input wire serial_pkg::ahb_req_t ahb_req,
  output serial_pkg::ahb_rsp_t ahb_rsp,
  // Shift clock pin
  input wire logic sclk_in,
  output logic sclk_out,
  output logic sclk_oe,
  // Master-out slave-in pin
  input wire logic mosi_in,
  output logic mosi_out,
  output logic mosi_oe,
  // Master-in slave-out pin
  input wire logic miso_in,
  output logic miso_out,
  output logic miso_oe,
  // Slave select, active low
  input wire logic slave_select_n,
  // Interrupt request
  output logic irq
);
  import serial_pkg::*;

  port_st_t st_ff;
  port_st_t nxt_st;

  logic en;
  logic master;
  logic wide;
  logic tick;
  logic sclk_q, sclk_rise, sclk_fall;
  logic ssn_q, ssn_fall;
  logic mosi_q;
  logic ap_ok;
  reg_sel_t ap_sel;
  logic [31:0] rd_mux;
  logic rd_data_ap;
  logic wr_data_dp;
  logic rise_ev, fall_ev, sample_ev, out_ev, lead_ev;
  logic in_bit;
  logic complete;
  logic [15:0] sh_shift;
  logic [5:0] nbits;
  logic [5:0] ntoggles;

  function automatic logic msb_of(input logic w, input logic [15:0] x);
    msb_of = w ? x[15] : x[7];
  endfunction

  function automatic logic [15:0] rb_load(input logic w, input logic [15:0] base,
                                          input logic [15:0] sh);
    rb_load = w ? sh : {base[15:8], sh[7:0]};
  endfunction

  assign en = st_ff.ctrl.port_enable;
  assign master = st_ff.ctrl.master_select;
  assign wide = st_ff.ctrl.word_width_select;
  assign nbits = wide ? BITS_WIDE : BITS_NARROW;
  assign ntoggles = wide ? TOGGLES_WIDE : TOGGLES_NARROW;

  ////////////////////////////////////////////////////////////////////////////
  // slave input synchronisers.
  sig_sync u_sclk_sync (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .d_in(sclk_in),
    .level(sclk_q),
    .rise(sclk_rise),
    .fall(sclk_fall)
  );

  sig_sync u_ssn_sync (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .d_in(slave_select_n),
    .level(ssn_q),
    .rise(),
    .fall(ssn_fall)
  );

  // Data is delayed by the same two stages so it stays aligned with the clock.
  sig_sync u_mosi_sync (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .d_in(mosi_in),
    .level(mosi_q),
    .rise(),
    .fall()
  );

  // master divider, half period of div + 1 system clocks.
  // a divider of one gives a quarter of the system clock as bit rate.
  shift_clk_div u_div (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .run(en && master && st_ff.running),
    .div(st_ff.ctrl.clock_divider),
    .tick(tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode; zero wait states, so every data phase follows its address phase.
  assign ap_ok = ahb_req.hsel && ahb_req.hready && ahb_req.htrans[HTRANS_ACTIVE_BIT];

  always_comb begin
    ap_sel = SEL_NONE;
    if (ahb_req.haddr[1:0] == 2'h0) begin
      if (ahb_req.haddr[31:2] == DATA_IDX) begin
        ap_sel = SEL_DATA;
      end else if (ahb_req.haddr[31:2] == CTRL_IDX) begin
        ap_sel = SEL_CTRL;
      end else if (ahb_req.haddr[31:2] == STAT_IDX) begin
        ap_sel = SEL_STAT;
      end
    end
  end

  // data reads see the read buffer, never the shifter.
  always_comb begin
    rd_mux = 32'h00000000;
    unique case (ap_sel)
      SEL_DATA: rd_mux[15:0] = st_ff.read_buf;
      SEL_CTRL: rd_mux[15:0] = st_ff.ctrl;
      SEL_STAT: begin
        rd_mux[STAT_BUSY_BIT] = st_ff.busy;
        rd_mux[STAT_FULL_BIT] = st_ff.full;
        rd_mux[STAT_OVR_BIT] = st_ff.receive_overrun;
      end
      SEL_NONE: rd_mux = 32'h00000000;
    endcase
  end

  assign rd_data_ap = ap_ok && !ahb_req.hwrite && (ap_sel == SEL_DATA);
  assign wr_data_dp = (st_ff.wr_sel == SEL_DATA) && en;

  ////////////////////////////////////////////////////////////////////////////
  // shift-clock edges: own divided clock as master, synchronised input as slave.
  assign rise_ev = en && (master ? (tick && !st_ff.sclk) : (sclk_rise && !ssn_q));
  assign fall_ev = en && (master ? (tick && st_ff.sclk) : (sclk_fall && !ssn_q));
  // edge mode picks the sampling and driving edges.
  assign sample_ev = st_ff.ctrl.clock_edge_alternate ? fall_ev : rise_ev;
  assign out_ev = st_ff.ctrl.clock_edge_alternate ? rise_ev : fall_ev;
  assign lead_ev = st_ff.ctrl.clock_idle_level ? fall_ev : rise_ev;

  // receive pin depends on the role.
  assign in_bit = master ? miso_in : mosi_q;
  // shift left, MSB first; in narrow width the high byte stands still.
  assign sh_shift = wide ? {st_ff.shifter[14:0], in_bit}
                         : {st_ff.shifter[15:8], st_ff.shifter[6:0], in_bit};

  // master ends on its last toggle, slave on its last sample.
  assign complete = en && (master ? (tick && st_ff.cnt == ntoggles - 6'h01)
                                  : (sample_ev && st_ff.cnt == nbits - 6'h01));

  always_comb begin
    nxt_st = st_ff;
    nxt_st.wr_sel = SEL_NONE;
    if (ap_ok) begin
      nxt_st.wr_sel = ahb_req.hwrite ? ap_sel : SEL_NONE;
      nxt_st.hrdata = ahb_req.hwrite ? 32'h00000000 : rd_mux;
    end
    if (st_ff.wr_sel == SEL_CTRL) begin
      nxt_st.ctrl = ctrl_t'(ahb_req.hwdata[15:0]);
    end
    // only a one in the overrun position clears it.
    if (st_ff.wr_sel == SEL_STAT && ahb_req.hwdata[STAT_OVR_BIT]) begin
      nxt_st.receive_overrun = 1'b0;
    end
    // reading the buffer lets a waiting word move in.
    if (rd_data_ap) begin
      if (st_ff.pending) begin
        nxt_st.read_buf = rb_load(wide, st_ff.read_buf, st_ff.shifter);
        nxt_st.pending = 1'b0;
        nxt_st.busy = 1'b0;
      end else begin
        nxt_st.full = 1'b0;
      end
    end
    // a data write loads the shifter and marks it busy.
    if (wr_data_dp) begin
      nxt_st.shifter = ahb_req.hwdata[15:0];
      nxt_st.valid = 1'b1;
      nxt_st.busy = 1'b1;
      nxt_st.out_bit = msb_of(wide, ahb_req.hwdata[15:0]);
      if (master) begin
        // overrun when both buffer and shifter still hold unread words.
        if (st_ff.full && st_ff.pending) begin
          nxt_st.receive_overrun = 1'b1;
        end
        nxt_st.pending = 1'b0;
        nxt_st.running = 1'b1;
        nxt_st.cnt = 6'h00;
      end
    end
    // one bit in per sampling edge, one bit out per driving edge.
    if (sample_ev) begin
      nxt_st.shifter = sh_shift;
      if (!master) begin
        nxt_st.cnt = st_ff.cnt + 6'h01;
      end
    end
    // driving edge presents the current MSB, bit 14 (bit 6 in narrow width) after the first shift.
    if (out_ev) begin
      nxt_st.out_bit = msb_of(wide, st_ff.shifter);
    end
    // master toggles are counted to bound the pulse train.
    if (tick) begin
      nxt_st.sclk = !st_ff.sclk;
      nxt_st.cnt = st_ff.cnt + 6'h01;
    end
    if (!master) begin
      // first leading edge under select marks the slave busy.
      if (lead_ev && !st_ff.busy) begin
        nxt_st.busy = 1'b1;
      end
      // MSB of the active byte goes out as soon as select is asserted.
      if (ssn_fall) begin
        nxt_st.out_bit = msb_of(wide, st_ff.shifter);
      end
      // released select realigns the bit count.
      if (ssn_q) begin
        nxt_st.cnt = 6'h00;
      end
    end
    // completion fills the buffer only if it has been read.
    if (complete) begin
      nxt_st.running = 1'b0;
      nxt_st.cnt = 6'h00;
      nxt_st.valid = 1'b0;
      if (!nxt_st.full) begin
        nxt_st.read_buf = rb_load(wide, nxt_st.read_buf, sample_ev ? sh_shift : st_ff.shifter);
        nxt_st.full = 1'b1;
        nxt_st.busy = 1'b0;
      end else begin
        nxt_st.pending = 1'b1;
      end
    end
    // master clock rests at the chosen idle level.
    if (nxt_st.ctrl.master_select && !nxt_st.running) begin
      nxt_st.sclk = nxt_st.ctrl.clock_idle_level;
    end
    // disabling the port drops all status and any transfer.
    if (!nxt_st.ctrl.port_enable) begin
      nxt_st.busy = 1'b0;
      nxt_st.full = 1'b0;
      nxt_st.receive_overrun = 1'b0;
      nxt_st.pending = 1'b0;
      nxt_st.running = 1'b0;
      nxt_st.cnt = 6'h00;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_ff <= PORT_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign ahb_rsp.hrdata = st_ff.hrdata;
  assign ahb_rsp.hreadyout = 1'b1;
  assign ahb_rsp.hresp = 1'b0;

  // pin roles follow the master select.
  assign sclk_out = st_ff.sclk;
  assign sclk_oe = master;
  assign mosi_out = st_ff.out_bit;
  assign mosi_oe = master;
  // slave drives miso only while enabled and selected.
  assign miso_oe = !master && en && !ssn_q;
  // echo only when enabled and no valid word is loaded.
  assign miso_out = (st_ff.ctrl.echo_back_enable && !st_ff.valid) ? mosi_q : st_ff.out_bit;

  // level interrupt from the enabled conditions; overrun counts only as master.
  assign irq = (st_ff.full && st_ff.ctrl.read_full_irq_en)
             | (!st_ff.busy && st_ff.ctrl.transfer_done_irq_en)
             | (st_ff.receive_overrun && st_ff.ctrl.overrun_irq_en && master);

  ////////////////////////////////////////////////////////////////////////////
  // Leading-edge counter seen on the clock output, used only by the checks.
  logic prev_sclk_ff;
  logic [5:0] lead_cnt_ff;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      prev_sclk_ff <= 1'b0;
      lead_cnt_ff <= 6'h00;
    end else begin
      prev_sclk_ff <= st_ff.sclk;
      if (wr_data_dp) begin
        lead_cnt_ff <= 6'h00;
      end else if (prev_sclk_ff == st_ff.ctrl.clock_idle_level && st_ff.sclk != prev_sclk_ff) begin
        lead_cnt_ff <= lead_cnt_ff + 6'h01;
      end
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);

  sequence s_master_write;
    wr_data_dp && master;
  endsequence

  sequence s_master_done;
    $fell(st_ff.running) && en && master;
  endsequence

  chk_pulse_count: assert property (
    s_master_done |=> lead_cnt_ff == nbits)
    else $error("master pulse count differs from word width");

  chk_idle_level: assert property (
    master && !st_ff.running && $stable(st_ff.ctrl) |-> st_ff.sclk == st_ff.ctrl.clock_idle_level)
    else $error("shift clock not at idle level");

  chk_write_busy: assert property (
    wr_data_dp |=> st_ff.busy || st_ff.full)
    else $error("data write did not mark busy");

  chk_ovr_set: assert property (
    s_master_write ##0 (st_ff.full && st_ff.pending) |=> st_ff.receive_overrun || !en)
    else $error("overrun not flagged");

  chk_ovr_hold: assert property (
    st_ff.receive_overrun && !(st_ff.wr_sel == SEL_STAT && ahb_req.hwdata[STAT_OVR_BIT])
      && nxt_st.ctrl.port_enable |=> st_ff.receive_overrun)
    else $error("overrun cleared without a one written");

  chk_disable_clear: assert property (
    !en |-> !st_ff.busy && !st_ff.full && !st_ff.receive_overrun)
    else $error("status set while disabled");

  chk_read_clear: assert property (
    rd_data_ap && !st_ff.pending && !complete && $stable(st_ff.ctrl) |=> !st_ff.full)
    else $error("read did not empty the buffer");

  chk_high_keep: assert property (
    complete && !wide && !st_ff.full |=> st_ff.read_buf[15:8] == $past(st_ff.read_buf[15:8]))
    else $error("narrow word changed read buffer high byte");

  chk_master_start: assert property (
    s_master_write |=> st_ff.running ##1 st_ff.running)
    else $error("master write did not start a transfer");

  chk_slave_float: assert property (
    !master && ssn_q |-> !miso_oe ##1 (ssn_q || !miso_oe || (en && !master)))
    else $error("slave drives output while deselected");

endmodule // serial_port

// ==== test/serial_peer.sv ====
// Behavioural serial peripheral that answers the port while it is master.
// Assumes the bench pulses start before each frame and sets width and edge mode.
`timescale 1ns/1ps
module serial_peer (
  // Link
  input wire logic sclk,
  input wire logic mosi,
  output logic miso,
  // Frame setup
  input wire logic start,
  input wire logic alt,
  input wire logic wide,
  input wire logic [15:0] tx,
  output logic [15:0] got
);
  int ecnt = 0;
  int scnt = 0;
  int idx = 0;

  initial begin
    miso = 1'b0;
    got = '0;
  end

  always @(posedge start) begin
    ecnt = 0;
    scnt = 0;
    idx = wide ? 15 : 7;
    miso = tx[idx];
  end

  ////////////////////////////////////////////////////////////////////////////
  // follows received clock
  // The line is turned over once the last bit is taken, so a stale level never passes.
  always @(sclk) begin
    if (sclk === !alt) begin
      got = {got[14:0], mosi};
      scnt++;
    end else if (scnt == (wide ? 16 : 8)) begin
      miso = ~miso;
    end else if (ecnt != 0) begin
      idx--;
      miso = tx[idx];
    end
    ecnt++;
  end
endmodule // serial_peer

// ==== test/serial_port_test.sv ====
// Self-checking bench: random master frames against the peer, overrun, disable, slave frame.
// Assumes the design files under hdl/ and the peer model beside this file.
`timescale 1ns/1ps
module serial_port_test;
  import serial_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  ahb_req_t req = '0;
  ahb_req_t bus_in;
  ahb_rsp_t rsp;
  logic sclk_out, sclk_oe, mosi_out, mosi_oe, miso_out, miso_oe, irq;
  logic m_sclk = 1'b0, m_mosi = 1'b0, sel_n = 1'b1;
  logic p_miso, p_start = 1'b0, p_alt = 1'b0, p_wide = 1'b0;
  logic [15:0] p_tx = '0, p_got, rb = '0;
  logic sclk_w, mosi_w, miso_w, prev_sclk = 1'b0;
  logic [31:0] rd;
  int error_cnt = 0, checks = 0, cyc = 0, last_t = 0, tog_cnt = 0, bad_gap = 0, exp_gap = 1;

  always #2.5 ref_clk = ~ref_clk;

  always_comb begin
    bus_in = req;
    bus_in.hready = rsp.hreadyout;
  end
  assign sclk_w = sclk_oe ? sclk_out : m_sclk;
  assign mosi_w = mosi_oe ? mosi_out : m_mosi;
  assign miso_w = miso_oe ? miso_out : p_miso;

  serial_port i_serial_port (.ref_clk(ref_clk), .rst_b(rst_b), .ahb_req(bus_in),
    .ahb_rsp(rsp), .sclk_in(sclk_w), .sclk_out(sclk_out), .sclk_oe(sclk_oe),
    .mosi_in(mosi_w), .mosi_out(mosi_out), .mosi_oe(mosi_oe), .miso_in(miso_w),
    .miso_out(miso_out), .miso_oe(miso_oe), .slave_select_n(sel_n), .irq(irq));
  serial_peer i_serial_peer (.sclk(sclk_w), .mosi(mosi_w), .miso(p_miso), .start(p_start),
    .alt(p_alt), .wide(p_wide), .tx(p_tx), .got(p_got));

  ////////////////////////////////////////////////////////////////////////////
  // Shift-clock monitor: toggles per frame and spacing between them.
  always @(posedge ref_clk) begin
    cyc++;
    if (sclk_out !== prev_sclk) begin
      if (tog_cnt > 0 && cyc - last_t != exp_gap) begin
        bad_gap++;
      end
      tog_cnt++;
      last_t = cyc;
    end
    prev_sclk = sclk_out;
  end

  task automatic final_report();
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic bus(input logic wr, input logic [29:0] idx, input logic [31:0] wd);
    @(posedge ref_clk);
    req.hsel <= 1'b1;
    req.htrans <= 2'b10;
    req.haddr <= {idx, 2'b00};
    req.hwrite <= wr;
    req.hsize <= 3'b010;
    @(posedge ref_clk);
    while (rsp.hreadyout !== 1'b1) @(posedge ref_clk);
    req.htrans <= 2'b00;
    req.hwdata <= wd;
    @(posedge ref_clk);
    while (rsp.hreadyout !== 1'b1) @(posedge ref_clk);
    rd = rsp.hrdata;
  endtask

  task automatic wr(input logic [29:0] idx, input logic [15:0] d);
    bus(1'b1, idx, {16'h0000, d});
  endtask

  task automatic rchk(input string what, input logic [29:0] idx, input logic [15:0] exp);
    bus(1'b0, idx, 32'h0000_0000);
    check(what, rd, {16'h0000, exp});
  endtask

  function automatic logic [15:0] mk_ctrl(input logic master, input logic wide,
      input logic [2:0] irq_en, input logic alt, input logic idle, input logic [6:0] div);
    ctrl_t c;
    c = CTRL_RESET;
    c.port_enable = 1'b1;
    c.master_select = master;
    c.word_width_select = wide;
    c.overrun_irq_en = irq_en[0];
    c.read_full_irq_en = irq_en[1];
    c.clock_edge_alternate = alt;
    c.clock_idle_level = idle;
    c.clock_divider = div;
    return c;
  endfunction

  // An 8-bit word lands in the low byte only; the high byte keeps what it had.
  function automatic logic [15:0] exp_rb(input logic wide, input logic [15:0] old,
      input logic [15:0] got);
    return wide ? got : {old[15:8], got[7:0]};
  endfunction

  // Settings change only with the port disabled, so a live clock never glitches.
  task automatic cfg(input logic [15:0] c);
    wr(CTRL_IDX, c & 16'hfffe);
    wr(CTRL_IDX, c);
  endtask

  task automatic frame(input logic wide, input logic alt, input logic idle,
      input logic [6:0] div, input logic [15:0] d, input logic [15:0] ptx);
    int n;
    logic [15:0] m;
    n = wide ? 32 : 16;
    m = wide ? 16'hffff : 16'h00ff;
    repeat (3) @(posedge ref_clk);
    p_wide = wide;
    p_alt = alt;
    p_tx = ptx;
    p_start = 1'b1;
    #1 p_start = 1'b0;
    exp_gap = div + 1;
    tog_cnt = 0;
    bad_gap = 0;
    wr(DATA_IDX, d);
    // next data write only after this frame has ended.
    while (tog_cnt < n) @(posedge ref_clk);
    repeat (2 * exp_gap + 2) @(posedge ref_clk);
    check("toggles", tog_cnt, n);
    check("gap", bad_gap, 0);
    check("idle level", sclk_out, idle);
    check("peer rx", p_got & m, d & m);
  endtask

  initial begin
    logic [15:0] d;
    logic [15:0] t;
    logic [6:0] dv;
    void'($urandom(56));
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    // every width, edge mode and idle level with random data
    for (int k = 0; k < 8; k++) begin
      d = 16'($urandom);
      t = 16'($urandom);
      dv = 7'($urandom_range(3, 1));
      cfg(mk_ctrl(1'b1, k[0], 3'b010, k[1], k[2], dv));
      frame(k[0], k[1], k[2], dv, d, t);
      check("irq full", irq, 1'b1);
      rchk("status full", STAT_IDX, 16'h0002);
      rb = exp_rb(k[0], rb, t);
      rchk("read buffer", DATA_IDX, rb);
      check("irq clear", irq, 1'b0);
      rchk("status empty", STAT_IDX, 16'h0000);
    end
    cfg(mk_ctrl(1'b1, 1'b1, 3'b001, 1'b0, 1'b0, 7'h01));
    frame(1'b1, 1'b0, 1'b0, 7'h01, 16'h1234, 16'ha5c3);
    frame(1'b1, 1'b0, 1'b0, 7'h01, 16'h5678, 16'h3c5a);
    rchk("status pending", STAT_IDX, 16'h0003);
    wr(DATA_IDX, 16'h0f0f);
    rchk("status overrun", STAT_IDX, 16'h0007);
    check("irq overrun", irq, 1'b1);
    wr(STAT_IDX, 16'h0000);
    rchk("overrun kept", STAT_IDX, 16'h0007);
    wr(STAT_IDX, 16'h0004);
    rchk("overrun cleared", STAT_IDX, 16'h0003);
    rchk("first word", DATA_IDX, 16'ha5c3);
    wr(CTRL_IDX, 16'h0000);
    rchk("disabled", STAT_IDX, 16'h0000);
    // Slave frame: the bench acts as external master in normal mode.
    wr(CTRL_IDX, 16'h0001);
    d = 16'($urandom);
    t = 16'($urandom);
    wr(DATA_IDX, d);
    rchk("slave busy", STAT_IDX, 16'h0001);
    check("miso float", miso_oe, 1'b0);
    sel_n <= 1'b0;
    repeat (4) @(posedge ref_clk);
    check("miso drive", miso_oe, 1'b1);
    for (int i = 7; i >= 0; i--) begin
      check("slave bit", miso_out, d[i]);
      m_mosi <= t[i];
      repeat (4) @(posedge ref_clk);
      m_sclk <= 1'b1;
      repeat (4) @(posedge ref_clk);
      m_sclk <= 1'b0;
      repeat (4) @(posedge ref_clk);
    end
    rchk("slave status", STAT_IDX, 16'h0002);
    bus(1'b0, DATA_IDX, 32'h0000_0000);
    check("slave rx", rd[7:0], t[7:0]);
    // Echo with no valid word loaded: the received line comes straight back.
    wr(CTRL_IDX, 16'h0009);
    m_mosi <= 1'b1;
    repeat (4) @(posedge ref_clk);
    check("echo high", miso_out, 1'b1);
    m_mosi <= 1'b0;
    repeat (4) @(posedge ref_clk);
    check("echo low", miso_out, 1'b0);
    sel_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    check("miso release", miso_oe, 1'b0);
    final_report();
  end

  initial begin
    repeat (40000) @(posedge ref_clk);
    error_cnt++;
    final_report();
  end
endmodule // serial_port_test
